//--- verilog/vtm_pkg.sv
package vtm_pkg;
    // Conversion timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CYCLE_TIME_MS = 200;
    localparam int N_CHAN = 5;
    localparam int CONV_CYCLES = CYCLE_TIME_MS * (CLK_HZ / 1000) / N_CHAN;
    localparam int FAST_DIV = 4;

    // Register addresses
    localparam logic [7:0] ADDR_RES_MID = 8'h20;
    localparam logic [7:0] ADDR_RES_LOW = 8'h21;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h22;
    localparam logic [7:0] ADDR_RES_SUP = 8'h23;
    localparam logic [7:0] ADDR_TEMP_HI = 8'h27;
    localparam logic [7:0] ADDR_TEMP_LO = 8'h28;
    localparam logic [7:0] ADDR_LIM_FIRST = 8'h2b;
    localparam logic [7:0] ADDR_LIM_LAST = 8'h32;
    localparam logic [7:0] ADDR_HOT = 8'h39;
    localparam logic [7:0] ADDR_HYST = 8'h3a;
    localparam logic [7:0] ADDR_CFG = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h41;
    localparam logic [7:0] ADDR_TMODE = 8'h42;
    localparam logic [7:0] ADDR_MASK = 8'h43;

    // Limit store layout and reset values
    localparam int LIM_DEPTH = 10;
    localparam logic [3:0] SLOT_HOT = 4'h8;
    localparam logic [3:0] SLOT_HYST = 4'h9;
    localparam logic [79:0] LIM_INIT = {8'h41, 8'h50, 8'had, 8'hd3, 8'had, 8'hd3,
                                        8'had, 8'hd3, 8'had, 8'hd3};

    // Configuration
    localparam logic [7:0] CFG_RESET = 8'h08;
    localparam int CFG_RUN_BIT = 0;
    localparam int CFG_ALERT_EN_BIT = 1;
    localparam int CFG_FAST_BIT = 5;
    localparam logic [10:0] TEMP_FAST_MASK = 11'h7fc;

    // Temperature interrupt modes
    localparam logic [1:0] TMODE_LATCHED = 2'h0;
    localparam logic [1:0] TMODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] TMODE_COMPARE = 2'h2;

    // Channels, also status bit positions
    localparam logic [2:0] CH_TEMP = 3'h0;
    localparam logic [2:0] CH_SUP = 3'h4;

    // Address-select connection codes
    localparam logic [1:0] ADD_GND = 2'h0;
    localparam logic [1:0] ADD_SDA = 2'h1;
    localparam logic [1:0] ADD_SCL = 2'h2;
    localparam logic [1:0] ADD_VCC = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CONV = 5'h02,
        ST_FETCH_HI = 5'h04,
        ST_FETCH_LO = 5'h08,
        ST_CHECK = 5'h10
    } vtm_state_t;
endpackage

//--- verilog/vtm_pin_filter.sv
`timescale 1ns/1ps
module vtm_pin_filter #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Raw pins and filtered levels
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic next_level;
            // Level moves only when two samples agree, dropping short spikes
            always_comb begin
                next_level = (s2 == s3) ? s3 : o_level[g];
            end
            always_ff @(posedge i_clock) begin
                if (!i_rstn) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                    o_level[g] <= 1'b1;
                end else begin
                    s1 <= i_pin[g];
                    s2 <= s1;
                    s3 <= s2;
                    o_level[g] <= next_level;
                end
            end
        end
    endgenerate
endmodule

//--- verilog/vtm_limit_mem.sv
`timescale 1ns/1ps
module vtm_limit_mem #(
    parameter int W = 8,
    parameter int D = 10,
    parameter logic [W*D-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Write port
    input wire logic i_we,
    input wire logic [3:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    // Read ports
    input wire logic [3:0] i_ra_addr,
    output logic [W-1:0] o_ra_q,
    input wire logic [3:0] i_rb_addr,
    output logic [W-1:0] o_rb_q
);

    logic [W-1:0] mem [D];

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            for (int i = 0; i < D; i++) begin
                mem[i] <= INIT[i*W +: W];
            end
            o_ra_q <= '0;
            o_rb_q <= '0;
        end else begin
            if (i_we && (int'(i_waddr) < D)) begin
                mem[i_waddr] <= i_wdata;
            end
            o_ra_q <= (int'(i_ra_addr) < D) ? mem[i_ra_addr] : '0;
            o_rb_q <= (int'(i_rb_addr) < D) ? mem[i_rb_addr] : '0;
        end
    end
endmodule

//--- verilog/vtm_monitor.sv
`timescale 1ns/1ps
// Functional notes
// - Voltage codes 8 bits, temperature 11 bits
// - Byte read gives top eight temperature bits
// - Word read gives 11 bits, low five zero
// - Config bit 5: 9 bits, quarter time
// - Fast mode word read carries 9 bits
// - Byte LSB one degree, word eighth degree
// - Nominal voltage gives code 192
// - Config bit 0 starts monitoring
// - Order: temperature, mid, low, high, supply
// - Stopping mid-cycle finishes the cycle first
// - Restart always begins with temperature
// - Flag hot temperature or voltage out of window
// - Violation drives alert low, sets status bit
// - Status read releases alert, except comparator
// - Status read clears bits, except comparator
// - Address pin sampled at each transaction start
// - Spikes under 50 ns on pins ignored
// - Config bit 1 and mask gate alert
// - Latched, one-time and comparator temperature modes
// - Results at 27h and 20h to 23h
module vtm_monitor #(
    parameter int CONV_CYCLES = vtm_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Converter
    input wire logic [10:0] i_adc_code,
    output logic [2:0] o_adc_channel,
    output logic o_adc_fast,
    output logic o_busy,
    // Serial pins
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_add,
    output logic [1:0] o_slave_addr_lsb,
    // Alert pin, open drain
    output logic o_alert_out,
    output logic o_alert_oe
);

    localparam int TW = $clog2(CONV_CYCLES + 1);

    function automatic logic [4:0] lim_slot(input logic [7:0] a);
        logic [7:0] off;
        off = a - vtm_pkg::ADDR_LIM_FIRST;
        if (a >= vtm_pkg::ADDR_LIM_FIRST && a <= vtm_pkg::ADDR_LIM_LAST) begin
            return {1'b1, off[3:0]};
        end else if (a == vtm_pkg::ADDR_HOT) begin
            return {1'b1, vtm_pkg::SLOT_HOT};
        end else if (a == vtm_pkg::ADDR_HYST) begin
            return {1'b1, vtm_pkg::SLOT_HYST};
        end
        return 5'h00;
    endfunction

    // Register state
    logic [7:0] cfg, next_cfg, temp_shadow, next_temp_shadow, rdata, next_rdata;
    logic [4:0] mask, next_mask, status, next_status, rd_clr, status_set;
    logic [1:0] tmode, next_tmode;
    logic rd_mem, next_rd_mem, next_alert_oe;
    // Sequencer state
    vtm_pkg::vtm_state_t state, next_state;
    logic [2:0] chan, next_chan, vch, pins_f;
    logic [TW-1:0] timer, next_timer, conv_last;
    logic [10:0] temp_res, next_temp_res;
    logic [3:0][7:0] volt_res, next_volt_res;
    logic [7:0] lim_hi, next_lim_hi, lim_qa, lim_qb;
    logic [1:0] volt_idx, next_addr_lsb;
    logic temp_armed, next_temp_armed, temp_band_clr, temp_over, temp_below, volt_out;
    // Address select and limit store wiring
    logic sda_q, add_q, add_pend, next_add_pend, start_cond;
    logic [4:0] bus_slot;
    logic [3:0] seq_slot;

    vtm_pin_filter #(.W(3)) u_filter (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_pin({i_add, i_sda, i_scl}),
        .o_level(pins_f)
    );

    assign bus_slot = lim_slot(i_addr);
    assign vch = chan - 3'h1;
    assign volt_idx = vch[1:0];
    assign seq_slot = (chan == vtm_pkg::CH_TEMP) ?
        ((state == vtm_pkg::ST_FETCH_HI) ? vtm_pkg::SLOT_HOT : vtm_pkg::SLOT_HYST) :
        {1'b0, volt_idx, state != vtm_pkg::ST_FETCH_HI};

    vtm_limit_mem #(.W(8), .D(vtm_pkg::LIM_DEPTH), .INIT(vtm_pkg::LIM_INIT)) u_limits (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_we(i_wr & bus_slot[4]),
        .i_waddr(bus_slot[3:0]),
        .i_wdata(i_wdata),
        .i_ra_addr(bus_slot[3:0]),
        .o_ra_q(lim_qa),
        .i_rb_addr(seq_slot),
        .o_rb_q(lim_qb)
    );

    // Quarter conversion time in fast mode
    assign conv_last = cfg[vtm_pkg::CFG_FAST_BIT] ?
        TW'(CONV_CYCLES / vtm_pkg::FAST_DIV - 1) : TW'(CONV_CYCLES - 1);

    assign temp_over = $signed(temp_res[10:3]) > $signed(lim_hi);
    assign temp_below = $signed(temp_res[10:3]) < $signed(lim_qb);
    assign volt_out = (volt_res[volt_idx] > lim_hi) || (volt_res[volt_idx] < lim_qb);

    always_comb begin
        next_state = state;
        next_chan = chan;
        next_timer = timer;
        next_temp_res = temp_res;
        next_volt_res = volt_res;
        next_lim_hi = lim_hi;
        next_temp_armed = temp_armed;
        status_set = 5'h00;
        temp_band_clr = 1'b0;
        case (state)
            vtm_pkg::ST_IDLE: begin
                if (cfg[vtm_pkg::CFG_RUN_BIT]) begin
                    next_chan = vtm_pkg::CH_TEMP;
                    next_timer = '0;
                    next_state = vtm_pkg::ST_CONV;
                end
            end
            vtm_pkg::ST_CONV: begin
                if (timer == conv_last) begin
                    next_timer = '0;
                    next_state = vtm_pkg::ST_FETCH_HI;
                    if (chan == vtm_pkg::CH_TEMP) begin
                        next_temp_res = cfg[vtm_pkg::CFG_FAST_BIT] ?
                            (i_adc_code & vtm_pkg::TEMP_FAST_MASK) : i_adc_code;
                    end else begin
                        next_volt_res[volt_idx] = i_adc_code[7:0];
                    end
                end else begin
                    next_timer = timer + 1'b1;
                end
            end
            vtm_pkg::ST_FETCH_HI: begin
                next_state = vtm_pkg::ST_FETCH_LO;
            end
            vtm_pkg::ST_FETCH_LO: begin
                next_lim_hi = lim_qb;
                next_state = vtm_pkg::ST_CHECK;
            end
            vtm_pkg::ST_CHECK: begin
                if (chan == vtm_pkg::CH_TEMP) begin
                    case (tmode)
                        vtm_pkg::TMODE_ONE_SHOT: begin
                            status_set[0] = temp_over & temp_armed;
                            if (temp_over) begin
                                next_temp_armed = 1'b0;
                            end else if (temp_below) begin
                                next_temp_armed = 1'b1;
                            end
                        end
                        vtm_pkg::TMODE_COMPARE: begin
                            status_set[0] = temp_over;
                            temp_band_clr = temp_below;
                        end
                        default: begin
                            status_set[0] = temp_over;
                        end
                    endcase
                end else begin
                    status_set[chan] = volt_out;
                end
                if (chan == vtm_pkg::CH_SUP) begin
                    next_chan = vtm_pkg::CH_TEMP;
                    next_state = cfg[vtm_pkg::CFG_RUN_BIT] ? vtm_pkg::ST_CONV : vtm_pkg::ST_IDLE;
                end else begin
                    next_chan = chan + 3'h1;
                    next_state = vtm_pkg::ST_CONV;
                end
            end
            default: begin
                next_state = vtm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state <= vtm_pkg::ST_IDLE;
            chan <= 3'h0;
            timer <= '0;
            temp_res <= 11'h000;
            volt_res <= '0;
            lim_hi <= 8'h00;
            temp_armed <= 1'b1;
            o_busy <= 1'b0;
        end else begin
            state <= next_state;
            chan <= next_chan;
            timer <= next_timer;
            temp_res <= next_temp_res;
            volt_res <= next_volt_res;
            lim_hi <= next_lim_hi;
            temp_armed <= next_temp_armed;
            o_busy <= next_state != vtm_pkg::ST_IDLE;
        end
    end

    always_comb begin
        next_cfg = cfg;
        next_tmode = tmode;
        next_mask = mask;
        next_temp_shadow = temp_shadow;
        next_rdata = 8'h00;
        next_rd_mem = 1'b0;
        rd_clr = 5'h00;
        if (i_rd) begin
            next_rd_mem = bus_slot[4];
            case (i_addr)
                vtm_pkg::ADDR_RES_MID: next_rdata = volt_res[0];
                vtm_pkg::ADDR_RES_LOW: next_rdata = volt_res[1];
                vtm_pkg::ADDR_RES_HIGH: next_rdata = volt_res[2];
                vtm_pkg::ADDR_RES_SUP: next_rdata = volt_res[3];
                vtm_pkg::ADDR_TEMP_HI: begin
                    next_rdata = temp_res[10:3];
                    next_temp_shadow = {temp_res[2:0], 5'h00};
                end
                vtm_pkg::ADDR_TEMP_LO: next_rdata = temp_shadow;
                vtm_pkg::ADDR_CFG: next_rdata = cfg;
                vtm_pkg::ADDR_STATUS: begin
                    next_rdata = {3'h0, status};
                    rd_clr = (tmode == vtm_pkg::TMODE_COMPARE) ? 5'h1e : 5'h1f;
                end
                vtm_pkg::ADDR_TMODE: next_rdata = {6'h00, tmode};
                vtm_pkg::ADDR_MASK: next_rdata = {3'h0, mask};
                default: next_rdata = 8'h00;
            endcase
        end
        if (i_wr) begin
            case (i_addr)
                vtm_pkg::ADDR_CFG: next_cfg = i_wdata;
                vtm_pkg::ADDR_TMODE: next_tmode = i_wdata[1:0];
                vtm_pkg::ADDR_MASK: next_mask = i_wdata[4:0];
                default: next_cfg = cfg;
            endcase
        end
        next_status = (status & ~rd_clr & ~{4'h0, temp_band_clr}) | status_set;
        next_alert_oe = cfg[vtm_pkg::CFG_ALERT_EN_BIT] && ((next_status & ~mask) != 5'h00);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            cfg <= vtm_pkg::CFG_RESET;
            tmode <= vtm_pkg::TMODE_LATCHED;
            mask <= 5'h00;
            status <= 5'h00;
            temp_shadow <= 8'h00;
            rdata <= 8'h00;
            rd_mem <= 1'b0;
            o_alert_oe <= 1'b0;
            o_alert_out <= 1'b0;
            o_adc_fast <= 1'b0;
        end else begin
            cfg <= next_cfg;
            tmode <= next_tmode;
            mask <= next_mask;
            status <= next_status;
            temp_shadow <= next_temp_shadow;
            rdata <= next_rdata;
            rd_mem <= next_rd_mem;
            o_alert_oe <= next_alert_oe;
            o_alert_out <= 1'b0;
            o_adc_fast <= next_cfg[vtm_pkg::CFG_FAST_BIT];
        end
    end

    // Limit reads come from the store's output register
    assign o_rdata = rd_mem ? lim_qa : rdata;
    assign o_adc_channel = chan;

    // Address pin classified at start condition
    assign start_cond = pins_f[0] & sda_q & ~pins_f[1];

    always_comb begin
        next_add_pend = add_pend;
        next_addr_lsb = o_slave_addr_lsb;
        if (start_cond) begin
            next_add_pend = pins_f[2];
            if (!pins_f[2]) begin
                next_addr_lsb = add_q ? vtm_pkg::ADD_SDA : vtm_pkg::ADD_GND;
            end
        end else if (add_pend && !pins_f[0]) begin
            next_add_pend = 1'b0;
            next_addr_lsb = pins_f[2] ? vtm_pkg::ADD_VCC : vtm_pkg::ADD_SCL;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            sda_q <= 1'b1;
            add_q <= 1'b0;
            add_pend <= 1'b0;
            o_slave_addr_lsb <= vtm_pkg::ADD_GND;
        end else begin
            sda_q <= pins_f[1];
            add_q <= pins_f[2];
            add_pend <= next_add_pend;
            o_slave_addr_lsb <= next_addr_lsb;
        end
    end
endmodule

//--- verification/vtm_checker.sv
`timescale 1ns/1ps
module vtm_checker #(
    parameter int CONV_CYCLES = 40
) (
    // Clock, reset and register port
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Converter and pins
    input wire logic [10:0] i_adc_code,
    input wire logic [2:0] o_adc_channel,
    input wire logic o_adc_fast,
    input wire logic o_busy,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_add,
    input wire logic [1:0] o_slave_addr_lsb,
    input wire logic o_alert_out,
    input wire logic o_alert_oe
);
    localparam int MIN_DWELL = CONV_CYCLES / 4;
    logic [7:0] cfg_q;
    logic [7:0] next_cfg_q;
    logic [2:0] last_ch;
    int dwell;
    int next_dwell;

    // Shadow of the configuration and time spent on one channel
    always_comb begin
        next_cfg_q = cfg_q;
        if (i_wr && i_addr == vtm_pkg::ADDR_CFG) begin
            next_cfg_q = i_wdata;
        end
        next_dwell = (o_adc_channel != last_ch) ? 0 : dwell + 1;
    end
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            cfg_q <= vtm_pkg::CFG_RESET;
            dwell <= 0;
            last_ch <= 3'h0;
        end else begin
            cfg_q <= next_cfg_q;
            dwell <= next_dwell;
            last_ch <= o_adc_channel;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_fast;
        o_adc_fast == cfg_q[vtm_pkg::CFG_FAST_BIT];
    endproperty
    a_fast: assert property (p_fast) else $error("fast flag differs from config");
    property p_alert_gate;
        !cfg_q[1] && !$past(cfg_q[1]) |-> !o_alert_oe;
    endproperty
    a_alert_gate: assert property (p_alert_gate) else $error("alert while disabled");
    property p_start;
        !o_busy && cfg_q[0] |-> ##[1:2] o_busy;
    endproperty
    a_start: assert property (p_start) else $error("run bit did not start sequencer");
    property p_stop_hold;
        o_busy && !cfg_q[0] && o_adc_channel != vtm_pkg::CH_SUP |=> o_busy;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("cycle cut short");
    property p_busy_fall;
        $fell(o_busy) |-> $past(o_adc_channel) == vtm_pkg::CH_SUP;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("idle before supply channel");
    property p_restart;
        $rose(o_busy) |-> o_adc_channel == vtm_pkg::CH_TEMP;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not at temperature");
    property p_order;
        o_adc_channel != $past(o_adc_channel) |-> o_adc_channel == $past(o_adc_channel) + 3'h1
            || (o_adc_channel == vtm_pkg::CH_TEMP && $past(o_adc_channel) == vtm_pkg::CH_SUP);
    endproperty
    a_order: assert property (p_order) else $error("channel order broken");
    property p_dwell;
        o_adc_channel != last_ch |-> dwell >= MIN_DWELL;
    endproperty
    a_dwell: assert property (p_dwell) else $error("conversion too short");
endmodule

bind vtm_monitor vtm_checker #(.CONV_CYCLES(CONV_CYCLES)) u_checker (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_adc_code(i_adc_code),
    .o_adc_channel(o_adc_channel), .o_adc_fast(o_adc_fast), .o_busy(o_busy),
    .i_scl(i_scl), .i_sda(i_sda), .i_add(i_add), .o_slave_addr_lsb(o_slave_addr_lsb),
    .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe));

//--- verification/vtm_far_end.sv
`timescale 1ns/1ps
module vtm_far_end (
    // Converter side
    input wire logic [2:0] i_adc_channel,
    output logic [10:0] o_adc_code,
    // Serial pins, pulled up when released
    output logic o_scl,
    output logic o_sda,
    output logic o_add
);
    logic [10:0] codes [5];
    logic [1:0] mode;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        mode = 2'h0;
    end
    assign o_adc_code = (i_adc_channel <= 3'h4) ? codes[i_adc_channel] : 11'h7ff;
    always_comb begin
        case (mode)
            2'h0: o_add = 1'b0;
            2'h1: o_add = o_sda;
            2'h2: o_add = o_scl;
            default: o_add = 1'b1;
        endcase
    end
    // One short frame; the clock stands high outside frames
    task automatic frame(input logic [1:0] m);
        mode = m;
        #437;
        o_sda = 1'b0;
        #400 o_scl = 1'b0;
        repeat (2) begin
            #400 o_scl = 1'b1;
            #400 o_scl = 1'b0;
        end
        #400 o_scl = 1'b1;
        #400 o_sda = 1'b1;
        #400;
    endtask
    task automatic spike(input logic [1:0] m);
        mode = m;
        #437 o_sda = 1'b0;
        #30 o_sda = 1'b1;
        #800;
    endtask
endmodule

//--- verification/vtm_monitor_tb_top.sv
`timescale 1ns/1ps
module vtm_monitor_tb_top;
    localparam int CONV = 40;
    logic i_clock;
    logic i_rstn;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    logic [10:0] i_adc_code;
    logic [2:0] o_adc_channel;
    logic o_adc_fast;
    logic o_busy;
    logic i_scl;
    logic i_sda;
    logic i_add;
    logic [1:0] o_slave_addr_lsb;
    logic o_alert_out;
    logic o_alert_oe;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int busy_len;
    logic [14:0] order;

    vtm_monitor #(.CONV_CYCLES(CONV)) dut (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_adc_code(i_adc_code),
        .o_adc_channel(o_adc_channel), .o_adc_fast(o_adc_fast), .o_busy(o_busy),
        .i_scl(i_scl), .i_sda(i_sda), .i_add(i_add), .o_slave_addr_lsb(o_slave_addr_lsb),
        .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe));
    vtm_far_end far (.i_adc_channel(o_adc_channel), .o_adc_code(i_adc_code),
        .o_scl(i_scl), .o_sda(i_sda), .o_add(i_add));

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic results();
        $display("Checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic do_reset();
        @(posedge i_clock);
        i_rstn <= 1'b0;
        repeat (4) @(posedge i_clock);
        i_rstn <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        check(name, {8'h00, o_rdata}, {8'h00, exp});
    endtask
    // Start, stop at once, then follow the one cycle that must still run
    task automatic run_cycle(input logic [7:0] cfg);
        logic [2:0] last;
        last = 3'h7;
        order = '0;
        busy_len = 0;
        wr(vtm_pkg::ADDR_CFG, cfg);
        wr(vtm_pkg::ADDR_CFG, cfg & 8'hfe);
        for (int n = 0; n < 3000 && !(busy_len > 0 && !o_busy); n++) begin
            @(negedge i_clock);
            if (o_busy) begin
                busy_len++;
                if (o_adc_channel !== last) begin
                    order = {order[11:0], o_adc_channel};
                    last = o_adc_channel;
                end
            end
        end
        check("busy_end", {15'h0, o_busy}, 16'h0000);
        check("order", {1'b0, order}, {1'b0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4});
    endtask

    initial begin
        i_rstn = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        for (int k = 1; k < 5; k++) far.codes[k] = 11'h0c0;
        far.codes[0] = 11'h0cc;
        do_reset();
        rd(vtm_pkg::ADDR_CFG, 8'h08, "cfg_reset");
        rd(8'h2b, 8'hd3, "lim_high");
        rd(8'h2c, 8'had, "lim_low");
        rd(vtm_pkg::ADDR_HOT, 8'h50, "hot_reset");
        rd(vtm_pkg::ADDR_STATUS, 8'h00, "status_reset");
        rd(8'h50, 8'h00, "unmapped");
        // Nominal inputs, 25.5 degrees
        run_cycle(8'h03);
        check("slow_cycle", 16'(busy_len >= 5 * CONV), 16'h0001);
        for (int k = 0; k < 4; k++) rd(8'(8'h20 + k), 8'hc0, "volt_nominal");
        rd(vtm_pkg::ADDR_TEMP_HI, 8'h19, "temp_byte");
        rd(vtm_pkg::ADDR_TEMP_LO, 8'h80, "temp_low");
        rd(vtm_pkg::ADDR_STATUS, 8'h00, "status_ok");
        check("alert_idle", {15'h0, o_alert_oe}, 16'h0000);
        // Hot, mid rail high, low rail low
        far.codes[0] = 11'h2d0;
        far.codes[1] = 11'h0e0;
        far.codes[2] = 11'h090;
        run_cycle(8'h03);
        check("alert_set", {15'h0, o_alert_oe}, 16'h0001);
        rd(vtm_pkg::ADDR_STATUS, 8'h07, "status_viol");
        check("alert_rel", {15'h0, o_alert_oe}, 16'h0000);
        rd(vtm_pkg::ADDR_STATUS, 8'h00, "status_clr");
        // Masked temperature source
        far.codes[1] = 11'h0c0;
        far.codes[2] = 11'h0c0;
        wr(vtm_pkg::ADDR_MASK, 8'h01);
        run_cycle(8'h03);
        check("alert_mask", {15'h0, o_alert_oe}, 16'h0000);
        rd(vtm_pkg::ADDR_STATUS, 8'h01, "status_mask");
        wr(vtm_pkg::ADDR_MASK, 8'h00);
        // Comparator mode survives reads
        wr(vtm_pkg::ADDR_TMODE, 8'(vtm_pkg::TMODE_COMPARE));
        run_cycle(8'h03);
        rd(vtm_pkg::ADDR_STATUS, 8'h01, "status_cmp");
        check("alert_cmp", {15'h0, o_alert_oe}, 16'h0001);
        rd(vtm_pkg::ADDR_STATUS, 8'h01, "status_cmp2");
        // One-time mode fires once while hot; first pass with the alert disabled
        do_reset();
        wr(vtm_pkg::ADDR_TMODE, 8'(vtm_pkg::TMODE_ONE_SHOT));
        run_cycle(8'h01);
        check("alert_off", {15'h0, o_alert_oe}, 16'h0000);
        rd(vtm_pkg::ADDR_STATUS, 8'h01, "status_once");
        run_cycle(8'h03);
        rd(vtm_pkg::ADDR_STATUS, 8'h00, "status_once2");
        // Reset in mid cycle, then fast mode
        wr(vtm_pkg::ADDR_CFG, 8'h01);
        repeat (30) @(posedge i_clock);
        do_reset();
        far.codes[0] = 11'h2d7;
        run_cycle(8'h21);
        check("fast_flag", {15'h0, o_adc_fast}, 16'h0001);
        check("fast_cycle", 16'(busy_len <= 5 * (CONV / 4 + 4)), 16'h0001);
        rd(vtm_pkg::ADDR_TEMP_HI, 8'h5a, "fast_byte");
        rd(vtm_pkg::ADDR_TEMP_LO, 8'h80, "fast_low");
        // Address select for each wiring, then a spike across one clock edge
        for (int k = 0; k < 4; k++) begin
            far.frame(2'(3 - k));
            repeat (8) @(negedge i_clock);
            check("slave_lsb", {14'h0, o_slave_addr_lsb}, 16'(3 - k));
        end
        far.spike(vtm_pkg::ADD_SDA);
        repeat (8) @(negedge i_clock);
        check("spike", {14'h0, o_slave_addr_lsb}, 16'h0000);
        check("alert_level", {15'h0, o_alert_out}, 16'h0000);
        results();
    end
endmodule
